// ===== sim/pdm_cpu_model.sv
// CPU core model that issues the sleep instruction and tracks its program counter
`timescale 1ns/100ps
module pdm_cpu_model #(
   parameter int DLY = 2
) (
   input  wire logic  clk_i,
   input  wire logic  resetn_i,
   input  wire logic  pc_advance_i,
   input  wire logic  cpu_reset_i,
   output logic       sleep_exec_o,
   output logic [1:0] power_mode_select_o,
   output logic       global_interrupt_mask_o,
   output logic [15:0] pc_o
);
   // ----------------------------------------------------------------
   // Sleep instruction issue
   // ----------------------------------------------------------------
   initial begin
      sleep_exec_o = 1'b0;
      power_mode_select_o = 2'h0;
      global_interrupt_mask_o = 1'b1;
   end

   // One-cycle sleep pulse; the field is scrambled afterwards so only the captured mode counts
   task automatic sleep_cmd(input logic [1:0] mode, input logic mask);
      @(posedge clk_i);
      #DLY;
      global_interrupt_mask_o = mask;
      power_mode_select_o = mode;
      sleep_exec_o = 1'b1;
      @(posedge clk_i);
      #DLY;
      sleep_exec_o = 1'b0;
      power_mode_select_o = ~mode;
   endtask

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   // A reset wake restarts at zero, any other wake continues after the sleep
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_o <= 16'h0000;
      end else if (cpu_reset_i) begin
         pc_o <= 16'h0000;
      end else if (pc_advance_i) begin
         pc_o <= pc_o + 16'h0001;
      end
   end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module testbench
   import pdm_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk_i, resetn_i, sleep_exec_i, global_interrupt_mask_i, reset_pin_n_i, wd_timeout_i, nmi_i;
   logic [1:0] power_mode_select_i, resume_action_o;
   logic [2:0] external_interrupt_pins_i, ext_enable_i;
   logic [7:0] periph_irq_i, periph_enable_i, periph_no_sysclk_i, periph_no_wdclk_i;
   logic pll_locked_i, cpu_clk_en_o, sys_clk_en_o, wd_clk_en_o, pll_en_o, osc_en_o, clk_restart_o;
   logic pc_advance_o, cpu_reset_o, resume_o, full_speed_o, asleep_o;
   logic [15:0] pc_w, exp_pc;
   int num_errors, comparisons, cycles, got, ex;
   int exp_q[$];

   pdm_ctrl #(.N_EXT(3), .N_PER(8), .LOCK_CYCLES(4), .START_CYCLES(6)) u_dut (.*);
   pdm_cpu_model #(.DLY(2)) u_cpu (.clk_i(clk_i), .resetn_i(resetn_i), .pc_advance_i(pc_advance_o),
      .cpu_reset_i(cpu_reset_o), .sleep_exec_o(sleep_exec_i), .power_mode_select_o(power_mode_select_i),
      .global_interrupt_mask_o(global_interrupt_mask_i), .pc_o(pc_w));

   // Clock, PLL lock that follows its enable one cycle late, and the hang limit
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) pll_locked_i <= pll_en_o;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   // Outcome codes: 0 stays asleep, 1 reset, 2 NMI, 3 ISR, 4 next instruction, 5 clocks only
   function automatic int expect_out(int m, int s, int k);
      case (s)
         0: return 1;
         1: return (m == 3) ? 0 : 1;
         2: return 2;
         3: return k ? 4 : 3;
         4: return 5;
         5: return (m == 0) ? (k ? 4 : 3) : 0;
         6: return (m != 3) ? (k ? 4 : 3) : 0;
         default: return k ? 4 : 3;
      endcase
   endfunction

   // Enables {cpu, sys, wd, pll, osc} while asleep in each mode
   function automatic logic [4:0] expect_en(int m);
      case (m)
         0: return 5'h0f;
         1: return 5'h07;
         2: return 5'h05;
         default: return 5'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Stimulus helpers
   // ----------------------------------------------------------------
   task automatic set_src(int s, logic on, int b, int p);
      reset_pin_n_i = !(on && s == 0);
      wd_timeout_i = on && s == 1;
      nmi_i = on && s == 2;
      external_interrupt_pins_i = (on && (s == 3 || s == 4)) ? 3'(1 << b) : 3'h0;
      ext_enable_i = (s == 4) ? ~3'(1 << b) : 3'h7;
      periph_irq_i = (on && s >= 5) ? 8'(1 << p) : 8'h00;
      periph_enable_i = 8'hff;
      periph_no_sysclk_i = (8'($urandom) & ~8'(1 << p)) | ((s >= 6) ? 8'(1 << p) : 8'h00);
      periph_no_wdclk_i = (8'($urandom) & ~8'(1 << p)) | ((s >= 7) ? 8'(1 << p) : 8'h00);
   endtask

   // Waits a bounded time for a reset or resume pulse and classifies it
   task automatic wait_out(output int g);
      g = 0;
      for (int n = 0; n < 100 && g == 0; n++) begin
         @(posedge clk_i);
         #2;
         if (cpu_reset_o === 1'b1) g = 1;
         else if (resume_o === 1'b1) g = (resume_action_o === PDM_RES_NMI) ? 2 :
                                         (resume_action_o === PDM_RES_ISR) ? 3 : 4;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int b, p, k;
      resetn_i = 1'b0;
      pll_locked_i = 1'b1;
      exp_pc = 16'h0000;
      void'($urandom(32'h696c03dc));
      set_src(0, 1'b0, 0, 0);
      repeat (12) @(posedge clk_i);
      #2;
      resetn_i = 1'b1;
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 8; s++) begin
            b = $urandom % 3;
            p = $urandom % 8;
            k = $urandom % 2;
            for (int n = 0; n < 20 && asleep_o !== 1'b0; n++) @(posedge clk_i);
            u_cpu.sleep_cmd(2'(m), 1'(k));
            exp_pc = exp_pc + 16'h0001;
            `CHK("pc_adv", 1'b1, pc_advance_o)
            `CHK("asleep", 1'b1, asleep_o)
            `CHK("full_spd", 1'b0, full_speed_o)
            `CHK("enables", expect_en(m), {cpu_clk_en_o, sys_clk_en_o, wd_clk_en_o, pll_en_o, osc_en_o})
            set_src(s, 1'b1, b, p);
            if (s >= 2 && s <= 4) begin
               #1;
               `CHK("restart", 1'b1, clk_restart_o)
            end
            exp_q.push_back(expect_out(m, s, k));
            ex = exp_q.pop_front();
            wait_out(got);
            `CHK("outcome", (ex == 5) ? 0 : ex, got)
            if (got >= 2) `CHK("spd_up", 1'b1, full_speed_o)
            if (ex == 5) begin
               `CHK("held_clk", 4'hb, {asleep_o, cpu_clk_en_o, sys_clk_en_o, osc_en_o})
            end
            set_src(s, 1'b0, b, p);
            // A wake that never came is cleared through the reset pin
            if (got == 0) begin
               repeat (3) @(posedge clk_i);
               #2;
               `CHK("still_asl", expect_en(m), {cpu_clk_en_o, sys_clk_en_o, wd_clk_en_o, pll_en_o, osc_en_o})
               set_src(0, 1'b1, b, p);
               wait_out(got);
               `CHK("pin_exit", 1, got)
               set_src(0, 1'b0, b, p);
            end
            if (got == 1) exp_pc = 16'h0000;
            repeat (3) @(posedge clk_i);
            #2;
            `CHK("pc", exp_pc, pc_w)
            $display("test mode %0d source %0d done", m, s);
         end
      end
      report_and_stop();
   end
endmodule

// ===== src/pdm_ctrl.sv
// Power-down mode controller top level
//
// Contract
// - Low-power mode entered only on sleep instruction, chosen by mode-select field.
// - Mode-select 00 CPU-halt, 01 peripheral-halt, 10 PLL-off, 11 oscillator-off.
// - CPU clock always stopped while sleeping; only reset, watchdog, NMI, pin or peripheral interrupts wake.
// - External reset pin ends every low-power mode.
// - Watchdog reset ends first three modes; watchdog clock frozen in oscillator-off.
// - NMI and external pins restart clocks through a purely combinational path.
// - Masked external interrupt restarts clocks but CPU stays asleep.
// - CPU-halt keeps system clock; any unmasked peripheral interrupt ends it.
// - Peripheral-halt and PLL-off stop the system clock domain.
// - Those two modes end on peripheral interrupts only if unmasked and independent of system clock.
// - Oscillator-off stops all clocks; no watchdog or clocked peripheral exit.
// - Oscillator-off ends on unmasked peripheral wakeups needing neither clock.
// - Peripheral wakeups accepted in peripheral-halt, PLL-off and oscillator-off.
// - Program counter advances once on sleep; resume after the sleep instruction.
// - Reset or NMI wakeup takes its service routine immediately.
// - Maskable wakeup with global mask 0 runs the service routine first.
// - Maskable wakeup with global mask 1 continues straight after sleep.
// - CPU clock domain excludes interrupt control registers, which use system clock.
// - After PLL-off or oscillator-off, wait for PLL lock before full speed; a reset wake goes to full speed without the wait.
`timescale 1ns/100ps
module pdm_ctrl
   import pdm_pkg::*;
#(
   parameter int N_EXT        = 3,
   parameter int N_PER        = 8,
   parameter int LOCK_CYCLES  = PDM_PLL_LOCK_CYCLES,
   parameter int START_CYCLES = PDM_OSC_START_CYCLES
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             sleep_exec_i,
   input  wire logic [1:0]       power_mode_select_i,
   input  wire logic             global_interrupt_mask_i,
   input  wire logic             reset_pin_n_i,
   input  wire logic             wd_timeout_i,
   input  wire logic             nmi_i,
   input  wire logic [N_EXT-1:0] external_interrupt_pins_i,
   input  wire logic [N_EXT-1:0] ext_enable_i,
   input  wire logic [N_PER-1:0] periph_irq_i,
   input  wire logic [N_PER-1:0] periph_enable_i,
   input  wire logic [N_PER-1:0] periph_no_sysclk_i,
   input  wire logic [N_PER-1:0] periph_no_wdclk_i,
   input  wire logic             pll_locked_i,
   output logic                  cpu_clk_en_o,
   output logic                  sys_clk_en_o,
   output logic                  wd_clk_en_o,
   output logic                  pll_en_o,
   output logic                  osc_en_o,
   output logic                  clk_restart_o,
   output logic                  pc_advance_o,
   output logic                  cpu_reset_o,
   output logic                  resume_o,
   output logic [1:0]            resume_action_o,
   output logic                  full_speed_o,
   output logic                  asleep_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pdm_state_type      state;
      logic [1:0]         mode;
      logic [PDM_CNT_W-1:0] cnt;
      logic               pc_adv;
      logic               resume;
      pdm_resume_type     action;
      logic               cpu_rst;
      logic               full_speed;
   } pdm_regs_type;

   pdm_regs_type r_reg;
   pdm_regs_type r_next;

   localparam logic [PDM_CNT_W-1:0] LOCK_N  = PDM_CNT_W'(LOCK_CYCLES);
   localparam logic [PDM_CNT_W-1:0] START_N = PDM_CNT_W'(START_CYCLES);

   logic sleeping;
   logic wake_restart;
   logic wake_exit;
   logic wake_maskable;
   logic reset_wake;

   // ----------------------------------------------------------------
   // Wakeup qualification
   // ----------------------------------------------------------------
   pdm_wake_decode #(
      .N_EXT (N_EXT),
      .N_PER (N_PER)
   ) u_wake (
      .mode_i                    (r_reg.mode),
      .nmi_i                     (nmi_i),
      .external_interrupt_pins_i (external_interrupt_pins_i),
      .ext_enable_i              (ext_enable_i),
      .periph_irq_i              (periph_irq_i),
      .periph_enable_i           (periph_enable_i),
      .periph_no_sysclk_i        (periph_no_sysclk_i),
      .periph_no_wdclk_i         (periph_no_wdclk_i),
      .clk_restart_o             (wake_restart),
      .full_exit_o               (wake_exit),
      .maskable_o                (wake_maskable)
   );

   // System and watchdog clocks held off only in the sleep state itself; a masked pin hit lifts them
   assign sleeping = (r_reg.state == PDM_SLEEP) && !wake_restart;

   pdm_gate_map u_gate (
      .sleep_i      (sleeping),
      .mode_i       (r_reg.mode),
      .cpu_clk_en_o (),
      .sys_clk_en_o (sys_clk_en_o),
      .wd_clk_en_o  (wd_clk_en_o),
      .pll_en_o     (),
      .osc_en_o     ()
   );

   // CPU clock stays off until a full exit, even after clocks restart
   assign cpu_clk_en_o = (r_reg.state == PDM_RUN) || (r_reg.state == PDM_RESUME);
   // PLL off while asleep in PLL-off and oscillator-off and during oscillator start-up, oscillator only in oscillator-off; a masked pin wake powers them again
   assign pll_en_o     = !((r_reg.state == PDM_SLEEP) && r_reg.mode[1] && !wake_restart)
                         && (r_reg.state != PDM_OSC_WAIT);
   assign osc_en_o     = !((r_reg.state == PDM_SLEEP) && (r_reg.mode == PDM_SEL_OSC_OFF)
                         && !wake_restart);

   // Watchdog reset only counts when its clock runs
   assign reset_wake = !reset_pin_n_i ||
                       (wd_timeout_i && (r_reg.mode != PDM_SEL_OSC_OFF));

   assign clk_restart_o   = wake_restart;
   assign pc_advance_o    = r_reg.pc_adv;
   assign cpu_reset_o     = r_reg.cpu_rst;
   assign resume_o        = r_reg.resume;
   assign resume_action_o = r_reg.action;
   assign full_speed_o    = r_reg.full_speed;
   assign asleep_o        = (r_reg.state != PDM_RUN);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      r_next         = r_reg;
      r_next.pc_adv  = 1'b0;
      r_next.resume  = 1'b0;
      r_next.cpu_rst = 1'b0;
      unique case (r_reg.state)
         PDM_RUN: begin
            r_next.full_speed = 1'b1;
            if (!reset_pin_n_i) begin
               r_next.cpu_rst = 1'b1;
            end else if (sleep_exec_i) begin
               r_next.mode   = power_mode_select_i;
               r_next.pc_adv = 1'b1;
               r_next.state  = PDM_SLEEP;
               r_next.full_speed = 1'b0;
            end
         end
         PDM_SLEEP: begin
            // Reset outranks interrupts; it bypasses the resume path entirely
            if (reset_wake) begin
               r_next.cpu_rst = 1'b1;
               r_next.action  = PDM_RES_NMI;
               r_next.state   = PDM_RUN;
               r_next.full_speed = 1'b1;
            end else if (wake_exit) begin
               if (nmi_i) begin
                  r_next.action = PDM_RES_NMI;
               end else if (global_interrupt_mask_i) begin
                  r_next.action = PDM_RES_NEXT;
               end else begin
                  r_next.action = PDM_RES_ISR;
               end
               if (r_reg.mode == PDM_SEL_OSC_OFF) begin
                  r_next.cnt   = START_N;
                  r_next.state = PDM_OSC_WAIT;
               end else if (r_reg.mode == PDM_SEL_PLL_OFF) begin
                  r_next.cnt   = LOCK_N;
                  r_next.state = PDM_PLL_WAIT;
               end else begin
                  r_next.state = PDM_RESUME;
               end
            end else if (wake_restart) begin
               r_next.state = PDM_HELD;
            end
         end
         PDM_HELD: begin
            // Clocks run but the CPU remains idle until a real exit
            if (reset_wake) begin
               r_next.cpu_rst = 1'b1;
               r_next.state   = PDM_RUN;
            end else if (wake_exit) begin
               r_next.action = nmi_i ? PDM_RES_NMI :
                               (global_interrupt_mask_i ? PDM_RES_NEXT : PDM_RES_ISR);
               r_next.cnt    = LOCK_N;
               r_next.state  = r_reg.mode[1] ? PDM_PLL_WAIT : PDM_RESUME;
            end else if (!wake_restart) begin
               r_next.state = PDM_SLEEP;
            end
         end
         PDM_OSC_WAIT: begin
            if (!reset_pin_n_i) begin
               r_next.cpu_rst = 1'b1;
               r_next.state   = PDM_RUN;
            end else if (r_reg.cnt <= PDM_CNT_W'(1)) begin
               r_next.cnt   = LOCK_N;
               r_next.state = PDM_PLL_WAIT;
            end else begin
               r_next.cnt = r_reg.cnt - PDM_CNT_W'(1);
            end
         end
         PDM_PLL_WAIT: begin
            // Both the time budget and the lock flag must agree
            if (!reset_pin_n_i) begin
               r_next.cpu_rst = 1'b1;
               r_next.state   = PDM_RUN;
            end else if (r_reg.cnt <= PDM_CNT_W'(1) && pll_locked_i) begin
               r_next.state = PDM_RESUME;
            end else if (r_reg.cnt > PDM_CNT_W'(1)) begin
               r_next.cnt = r_reg.cnt - PDM_CNT_W'(1);
            end
         end
         PDM_RESUME: begin
            r_next.resume     = 1'b1;
            r_next.full_speed = 1'b1;
            r_next.state      = PDM_RUN;
         end
         default: begin
            r_next.state = PDM_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r_reg.state      <= PDM_RUN;
         r_reg.mode       <= PDM_MODE_RESET;
         r_reg.cnt        <= '0;
         r_reg.pc_adv     <= 1'b0;
         r_reg.resume     <= 1'b0;
         r_reg.action     <= PDM_RES_NEXT;
         r_reg.cpu_rst    <= 1'b0;
         r_reg.full_speed <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   enter_on_sleep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_RUN && reset_pin_n_i && sleep_exec_i) |=> (r_reg.state == PDM_SLEEP))
      else $error("sleep not entered");
   mode_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_RUN && reset_pin_n_i && sleep_exec_i)
      |=> (r_reg.mode == $past(power_mode_select_i)))
      else $error("mode not captured");
   mode_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP) |=> $stable(r_reg.mode))
      else $error("mode changed in sleep");
   cpu_clk_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP) |-> !cpu_clk_en_o)
      else $error("cpu clock on in sleep");
   sys_clk_map_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && !wake_restart && r_reg.mode != PDM_SEL_CPU_HALT) |-> !sys_clk_en_o)
      else $error("system clock on");
   osc_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && !wake_restart && r_reg.mode == PDM_SEL_OSC_OFF)
      |-> !(osc_en_o || wd_clk_en_o || pll_en_o))
      else $error("clock on in osc-off");
   pin_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && !reset_pin_n_i) |=> (cpu_reset_o && r_reg.state == PDM_RUN))
      else $error("reset pin ignored");
   wd_osc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode == PDM_SEL_OSC_OFF && reset_pin_n_i
       && !wake_restart) |=> (r_reg.state == PDM_SLEEP))
      else $error("osc-off left without source");
   masked_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && wake_restart && !wake_exit && !reset_wake)
      |-> (sys_clk_en_o && !cpu_clk_en_o) ##1 (r_reg.state == PDM_HELD))
      else $error("masked wake misbehaved");
   mask_resume_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && wake_exit && !reset_wake && !nmi_i && global_interrupt_mask_i)
      |=> (resume_action_o == PDM_RES_NEXT))
      else $error("wrong resume action");
   pc_once_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pc_advance_o |=> !pc_advance_o)
      else $error("pc advanced twice");
   wd_exit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && wd_timeout_i && r_reg.mode != PDM_SEL_OSC_OFF)
      |=> cpu_reset_o)
      else $error("watchdog wake lost");
   nmi_action_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && nmi_i && !reset_wake)
      |=> (resume_action_o == PDM_RES_NMI))
      else $error("nmi action wrong");
   isr_action_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && wake_exit && !reset_wake && !nmi_i && !global_interrupt_mask_i)
      |=> (resume_action_o == PDM_RES_ISR))
      else $error("isr action wrong");
   halt_periph_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode == PDM_SEL_CPU_HALT && !reset_wake
       && (|(periph_irq_i & periph_enable_i)))
      |=> (r_reg.state == PDM_RESUME && sys_clk_en_o))
      else $error("cpu-halt peripheral exit lost");
   sysclk_dep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode != PDM_SEL_CPU_HALT && !reset_wake && !nmi_i
       && !(|external_interrupt_pins_i) && !(|(periph_irq_i & periph_no_sysclk_i)))
      |=> (r_reg.state == PDM_SLEEP))
      else $error("clocked peripheral woke");
   wdclk_dep_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode == PDM_SEL_OSC_OFF && reset_pin_n_i && !nmi_i
       && !(|external_interrupt_pins_i) && !(|(periph_irq_i & periph_no_wdclk_i)))
      |=> (r_reg.state == PDM_SLEEP))
      else $error("watchdog-clocked peripheral woke");
   lock_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_PLL_WAIT && !pll_locked_i) |=> !full_speed_o)
      else $error("full speed before lock");
   halt_sysclk_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode == PDM_SEL_CPU_HALT) |-> sys_clk_en_o)
      else $error("system clock off in cpu-halt");
   resume_run_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      resume_o |-> (r_reg.state == PDM_RUN && full_speed_o && cpu_clk_en_o))
      else $error("resume without run");
   held_back_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_HELD && !wake_restart && !reset_wake) |=> (r_reg.state == PDM_SLEEP))
      else $error("held state stuck");
   held_clocks_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_HELD)
      |-> (!cpu_clk_en_o && sys_clk_en_o && wd_clk_en_o && pll_en_o && osc_en_o))
      else $error("held clocks wrong");
   pll_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (r_reg.state == PDM_SLEEP && r_reg.mode == PDM_SEL_PLL_OFF && !wake_restart)
      |-> (!pll_en_o && wd_clk_en_o && osc_en_o))
      else $error("pll-off map wrong");

endmodule

// ===== src/pdm_gate_map.sv
// Clock-domain enable map for each selected mode
`timescale 1ns/100ps
module pdm_gate_map
   import pdm_pkg::*;
(
   input  wire logic       sleep_i,
   input  wire logic [1:0] mode_i,
   output logic            cpu_clk_en_o,
   output logic            sys_clk_en_o,
   output logic            wd_clk_en_o,
   output logic            pll_en_o,
   output logic            osc_en_o
);

   // Off table; awake means everything runs
   always_comb begin
      cpu_clk_en_o = !sleep_i;
      sys_clk_en_o = !sleep_i || (mode_i == PDM_SEL_CPU_HALT);
      wd_clk_en_o  = !sleep_i || (mode_i != PDM_SEL_OSC_OFF);
      pll_en_o     = !sleep_i || (mode_i[1] == 1'b0);
      osc_en_o     = !sleep_i || (mode_i != PDM_SEL_OSC_OFF);
   end

endmodule

// ===== src/pdm_pkg.sv
// Package of constants and types for the power-down mode controller
package pdm_pkg;

   // ----------------------------------------------------------------
   // Mode-select encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] PDM_SEL_CPU_HALT   = 2'h0;
   localparam logic [1:0] PDM_SEL_PERIPH_HLT = 2'h1;
   localparam logic [1:0] PDM_SEL_PLL_OFF    = 2'h2;
   localparam logic [1:0] PDM_SEL_OSC_OFF    = 2'h3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int PDM_CLK_MHZ          = 125;
   localparam int PDM_PLL_LOCK_US      = 200;
   localparam int PDM_PLL_LOCK_CYCLES  = PDM_PLL_LOCK_US * PDM_CLK_MHZ;
   localparam int PDM_OSC_START_US     = 1000;
   localparam int PDM_OSC_START_CYCLES = PDM_OSC_START_US * PDM_CLK_MHZ;
   localparam int PDM_CNT_W            = 24;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] PDM_MODE_RESET = PDM_SEL_CPU_HALT;

   // Controller states
   typedef enum logic [2:0] {
      PDM_RUN      = 3'b000,
      PDM_SLEEP    = 3'b001,
      PDM_OSC_WAIT = 3'b010,
      PDM_PLL_WAIT = 3'b011,
      PDM_HELD     = 3'b100,
      PDM_RESUME   = 3'b101
   } pdm_state_type;

   // Resume action handed to the CPU
   typedef enum logic [1:0] {
      PDM_RES_NEXT = 2'b00,
      PDM_RES_ISR  = 2'b01,
      PDM_RES_NMI  = 2'b10
   } pdm_resume_type;

endpackage

// ===== src/pdm_wake_decode.sv
// Combinational wakeup qualification per mode
`timescale 1ns/100ps
module pdm_wake_decode
   import pdm_pkg::*;
#(
   parameter int N_EXT = 3,
   parameter int N_PER = 8
) (
   input  wire logic [1:0]       mode_i,
   input  wire logic             nmi_i,
   input  wire logic [N_EXT-1:0] external_interrupt_pins_i,
   input  wire logic [N_EXT-1:0] ext_enable_i,
   input  wire logic [N_PER-1:0] periph_irq_i,
   input  wire logic [N_PER-1:0] periph_enable_i,
   input  wire logic [N_PER-1:0] periph_no_sysclk_i,
   input  wire logic [N_PER-1:0] periph_no_wdclk_i,
   output logic                  clk_restart_o,
   output logic                  full_exit_o,
   output logic                  maskable_o
);

   // Per-peripheral eligibility depends on which clocks are stopped
   logic [N_PER-1:0] per_ok;
   logic             ext_any;
   logic             ext_unmasked;

   genvar g;
   generate
      for (g = 0; g < N_PER; g++) begin : g_per
         always_comb begin
            unique case (mode_i)
               PDM_SEL_CPU_HALT:   per_ok[g] = periph_irq_i[g] & periph_enable_i[g];
               PDM_SEL_PERIPH_HLT,
               PDM_SEL_PLL_OFF:    per_ok[g] = periph_irq_i[g] & periph_enable_i[g]
                                               & periph_no_sysclk_i[g];
               PDM_SEL_OSC_OFF:    per_ok[g] = periph_irq_i[g] & periph_enable_i[g]
                                               & periph_no_sysclk_i[g] & periph_no_wdclk_i[g];
            endcase
         end
      end
   endgenerate

   // Pin paths are pure gates so they work with every clock stopped
   assign ext_any       = |external_interrupt_pins_i;
   assign ext_unmasked  = |(external_interrupt_pins_i & ext_enable_i);
   assign clk_restart_o = nmi_i | ext_any | (|per_ok);
   assign full_exit_o   = nmi_i | ext_unmasked | (|per_ok);
   assign maskable_o    = ext_unmasked | (|per_ok);

endmodule
